// ---- ipr_top.sv ----
// ipr_top: first interrupt priority word behind an apb slave
// assumes apb master on mclk; arbitration lives outside and reads the levels
//
// The register offsets and register access over APB were decided locally.
module ipr_top (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [2:0]       timer_two_priority_level,
    output logic [2:0]       compare_two_priority_level,
    output logic [2:0]       capture_two_priority_level,
    output logic [2:0]       source_enable
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [15:0] interrupt_priority_word_one_reg;
    logic [15:0] interrupt_priority_word_one_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic [2:0]  timer_level_reg;
    logic [2:0]  timer_level_next;
    logic [2:0]  compare_level_reg;
    logic [2:0]  compare_level_next;
    logic [2:0]  capture_level_reg;
    logic [2:0]  capture_level_next;
    logic [2:0]  source_enable_reg;
    logic [2:0]  source_enable_next;
    logic [2:0]  timer_code;
    logic [2:0]  compare_code;
    logic [2:0]  capture_code;
    logic [2:0]  timer_level;
    logic [2:0]  compare_level;
    logic [2:0]  capture_level;
    logic [2:0]  enable_vec;
    logic        taken;
    logic        complete;
    logic        hit;
    logic        word_write;
    logic        read_taken;
    logic [15:0] wr_lanes;
    logic [31:0] read_word;

    // -------------------------------------------------------------------
    // field slices
    // -------------------------------------------------------------------
    // timer field slice
    assign timer_code   =
        interrupt_priority_word_one_reg[ipr_pkg::IPR_TIMER_LSB +: ipr_pkg::IPR_FIELD_W];
    assign compare_code =
        interrupt_priority_word_one_reg[ipr_pkg::IPR_COMPARE_LSB +: ipr_pkg::IPR_FIELD_W];
    assign capture_code =
        interrupt_priority_word_one_reg[ipr_pkg::IPR_CAPTURE_LSB +: ipr_pkg::IPR_FIELD_W];

    // -------------------------------------------------------------------
    // level decode
    // -------------------------------------------------------------------
    // one decoder per source keeps the three fields alike by construction
    ipr_level_decode u_timer (
        .code       (timer_code),
        .src_enable (enable_vec[2]),
        .level      (timer_level)
    );
    ipr_level_decode u_compare (
        .code       (compare_code),
        .src_enable (enable_vec[1]),
        .level      (compare_level)
    );
    ipr_level_decode u_capture (
        .code       (capture_code),
        .src_enable (enable_vec[0]),
        .level      (capture_level)
    );

    // -------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------
    // taken: first access cycle; complete: the cycle in which pready stands
    assign taken      = psel && penable && !pready_reg;
    assign complete   = psel && penable && pready_reg;
    assign hit        = (paddr == ipr_pkg::IPR_ADDR_PRIO_WORD) ||
                        (paddr == ipr_pkg::IPR_ADDR_SRC_ENABLE) ||
                        (paddr == ipr_pkg::IPR_ADDR_LEVEL_VIEW);
    assign wr_lanes   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    // a write lands only at the edge that closes the transfer, as the master sees it
    assign word_write = complete && pwrite && (paddr == ipr_pkg::IPR_ADDR_PRIO_WORD);
    assign read_taken = taken && !pwrite;

    // -------------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------------
    always_comb
    begin
        read_word = ipr_pkg::IPR_READ_ZERO;
        case (paddr)
            ipr_pkg::IPR_ADDR_PRIO_WORD:
            begin
                read_word[15:0] = interrupt_priority_word_one_reg & ipr_pkg::IPR_WRITE_MASK;
            end
            ipr_pkg::IPR_ADDR_SRC_ENABLE:
            begin
                read_word[2:0] = enable_vec;
            end
            ipr_pkg::IPR_ADDR_LEVEL_VIEW:
            begin
                read_word[ipr_pkg::IPR_VIEW_TIMER_LSB +: ipr_pkg::IPR_FIELD_W] = timer_level;
                read_word[ipr_pkg::IPR_VIEW_COMPARE_LSB +: ipr_pkg::IPR_FIELD_W] = compare_level;
                read_word[ipr_pkg::IPR_VIEW_CAPTURE_LSB +: ipr_pkg::IPR_FIELD_W] = capture_level;
            end
            default:
            begin
                read_word = ipr_pkg::IPR_READ_ZERO;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // priority word
    // -------------------------------------------------------------------
    always_comb
    begin
        interrupt_priority_word_one_next = interrupt_priority_word_one_reg;
        if (word_write)
        begin
            // spare bits never take a write; low strobes keep their byte
            interrupt_priority_word_one_next =
                (interrupt_priority_word_one_reg & ~(wr_lanes & ipr_pkg::IPR_WRITE_MASK)) |
                (pwdata[15:0] & wr_lanes & ipr_pkg::IPR_WRITE_MASK);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            interrupt_priority_word_one_reg <= ipr_pkg::IPR_RESET_WORD;
        end
        else
        begin
            interrupt_priority_word_one_reg <= interrupt_priority_word_one_next;
        end
    end

    // -------------------------------------------------------------------
    // bus answer
    // -------------------------------------------------------------------
    // read data is captured when taken so that it stands with pready
    always_comb
    begin
        prdata_next  = ipr_pkg::IPR_READ_ZERO;
        pready_next  = taken;
        pslverr_next = taken && !hit;
        if (read_taken)
        begin
            prdata_next = read_word;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prdata_reg  <= ipr_pkg::IPR_READ_ZERO;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // -------------------------------------------------------------------
    // level outputs
    // -------------------------------------------------------------------
    // levels lag the word by one cycle so outputs come from flops
    always_comb
    begin
        timer_level_next   = timer_level;
        compare_level_next = compare_level;
        capture_level_next = capture_level;
        source_enable_next = enable_vec;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            timer_level_reg   <= ipr_pkg::IPR_LEVEL_OFF;
            compare_level_reg <= ipr_pkg::IPR_LEVEL_OFF;
            capture_level_reg <= ipr_pkg::IPR_LEVEL_OFF;
            source_enable_reg <= 3'h0;
        end
        else
        begin
            timer_level_reg   <= timer_level_next;
            compare_level_reg <= compare_level_next;
            capture_level_reg <= capture_level_next;
            source_enable_reg <= source_enable_next;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign prdata                     = prdata_reg;
    assign pready                     = pready_reg;
    assign pslverr                    = pslverr_reg;
    assign timer_two_priority_level   = timer_level_reg;
    assign compare_two_priority_level = compare_level_reg;
    assign capture_two_priority_level = capture_level_reg;
    assign source_enable              = source_enable_reg;
endmodule

// ---- ipr_pkg.sv ----
// ipr_pkg: constants for the first interrupt priority word
// assumes a 32-bit apb master on the mclk domain; register offsets are our own choice
//
// Contract
// - timer two priority: 3-bit field at bits 14..12, 111 is level 7
// - compare two priority: 3-bit field at bits 10..8, same encoding
// - capture two priority: 3-bit field at bits 6..4, same encoding
// - code 000 disables a source; 001..111 give levels 1..7
package ipr_pkg;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [11:0] IPR_ADDR_PRIO_WORD   = 12'h000;
    localparam logic [11:0] IPR_ADDR_SRC_ENABLE  = 12'h004;
    localparam logic [11:0] IPR_ADDR_LEVEL_VIEW  = 12'h008;
    // -------------------------------------------------------------------
    // field layout
    // -------------------------------------------------------------------
    localparam int          IPR_FIELD_W          = 3;
    localparam int          IPR_TIMER_LSB        = 12;
    localparam int          IPR_COMPARE_LSB      = 8;
    localparam int          IPR_CAPTURE_LSB      = 4;
    localparam logic [15:0] IPR_WRITE_MASK       = 16'h7770;
    localparam logic [15:0] IPR_RESET_WORD       = 16'h4440;
    localparam logic [2:0]  IPR_LEVEL_OFF        = 3'h0;
    localparam logic [31:0] IPR_READ_ZERO        = 32'h00000000;
    // level view: one nibble per source
    localparam int          IPR_VIEW_TIMER_LSB   = 8;
    localparam int          IPR_VIEW_COMPARE_LSB = 4;
    localparam int          IPR_VIEW_CAPTURE_LSB = 0;
endpackage

// ---- ipr_level_decode.sv ----
// ipr_level_decode: turns one priority code into enable and level
// assumes a 3-bit code from the priority word on the same clock
module ipr_level_decode (
    input  wire logic [2:0] code,
    output logic            src_enable,
    output logic [2:0]      level
);
    assign src_enable = (code != ipr_pkg::IPR_LEVEL_OFF);
    assign level      = code;
endmodule

// ---- ipr_top_props.sv ----
// checker for ipr_top, port level only
// assumes it is bound onto ipr_top on the mclk domain
module ipr_top_props (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [3:0]  pstrb,
    input wire logic [2:0]  timer_two_priority_level,
    input wire logic [2:0]  compare_two_priority_level,
    input wire logic [2:0]  capture_two_priority_level,
    input wire logic [2:0]  source_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic wr_w;
    assign wr_w = psel && penable && pready && pwrite && paddr == 12'h000;
    chk_timer_field: assert property (wr_w && pstrb[1] |-> ##2
        timer_two_priority_level == $past(pwdata[14:12], 2)) else $error("timer level");
    chk_compare_field: assert property (wr_w && pstrb[1] |-> ##2
        compare_two_priority_level == $past(pwdata[10:8], 2)) else $error("compare level");
    chk_capture_field: assert property (wr_w && pstrb[0] |-> ##2
        capture_two_priority_level == $past(pwdata[6:4], 2)) else $error("capture level");
    chk_enable_code: assert property (source_enable == {timer_two_priority_level != 3'h0,
        compare_two_priority_level != 3'h0, capture_two_priority_level != 3'h0})
        else $error("source enable");
    chk_unimpl_zero: assert property (pready && !pwrite && paddr == 12'h000 |->
        (prdata & 32'hFFFF888F) == 32'h00000000) else $error("unimplemented bits");
    chk_reset_load: assert property ($past(reset) |=> {timer_two_priority_level,
        compare_two_priority_level, capture_two_priority_level} == 9'h124) else $error("reset");
    chk_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready");
    cover property (wr_w && pstrb == 4'h3);
    cover property (pready && pslverr);
    cover property (source_enable == 3'h0);
    cover property (psel && penable && pready && pwrite && paddr == 12'h004);
endmodule
bind ipr_top ipr_top_props chk_u (.mclk, .reset, .psel, .penable, .pwrite, .pready, .pslverr,
    .paddr, .pwdata, .prdata, .pstrb, .timer_two_priority_level, .compare_two_priority_level,
    .capture_two_priority_level, .source_enable);

// ---- ipr_top_test.sv ----
// bench for ipr_top: apb master, shadow word, queue of expected reads
// assumes nothing of the answer latency: each transfer waits for pready, bounded
module ipr_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, expq[$];
    logic [3:0]  pstrb = 4'h0;
    logic [2:0]  tl, cl, pl, se;
    logic [15:0] mdl = 16'h4440, m;
    int          failures = 0, n_compared = 0, seed = 20833;
    always #20 mclk = ~mclk;
    ipr_top dut_u (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .timer_two_priority_level(tl), .compare_two_priority_level(cl),
        .capture_two_priority_level(pl), .source_enable(se));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        if (expq.size() != 0)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %0d reads never answered", $time, expq.size());
        end
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk)
        if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0)
            chk(prdata, expq.pop_front());
    function automatic logic [31:0] exp_rd(input logic [11:0] a, input logic e);
        logic [31:0] r;
        r = 32'h00000000;
        if (!e && a == 12'h000)
            r = {16'h0000, mdl & 16'h7770};
        else if (!e && a == 12'h004)
            r = {29'h00000000, |mdl[14:12], |mdl[10:8], |mdl[6:4]};
        else if (!e && a == 12'h008)
            r = {21'h000000, mdl[14:12], 1'b0, mdl[10:8], 1'b0, mdl[6:4]};
        return r;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic e);
        int i;
        if (!w)
            expq.push_back(exp_rd(a, e));
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 9 && pready !== 1'b1; i++)
            @(posedge mclk);
        failures += (i == 9);
        if (i == 9)
            finish_test();
        chk(32'(pslverr), 32'(e));
        // lanes low keep their byte; spare bits never take a write
        m = {{8{s[1]}}, {8{s[0]}}} & 16'h7770;
        if (w && !e && a == 12'h000)
            mdl = (mdl & ~m) | (d[15:0] & m);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic lv();
        @(posedge mclk);
        chk(32'({tl, cl, pl, se}), 32'({mdl[14:12], mdl[10:8], mdl[6:4],
            |mdl[14:12], |mdl[10:8], |mdl[6:4]}));
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
        lv();
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, 12'h000, {16'hFFFF, 1'b1, c[2:0], 1'b1, c[2:0], 1'b1, c[2:0], 4'hF},
                4'h3, 1'b0);
            lv();
            apb(1'b0, 12'h008, 32'h0, 4'h0, 1'b0);
            apb(1'b0, 12'h004, 32'h0, 4'h0, 1'b0);
            apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
        end
        repeat (16)
        begin
            apb(1'b1, 12'h000, $random(seed), 4'($random(seed)), 1'b0);
            apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
            lv();
        end
        apb(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF, 1'b0);
        apb(1'b1, 12'h008, 32'h00000000, 4'hF, 1'b0);
        apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF, 1'b1);
        apb(1'b0, 12'h00C, 32'h0, 4'h0, 1'b1);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        mdl = 16'h4440;
        @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0, 4'h0, 1'b0);
        lv();
        finish_test();
    end
endmodule
